// >>> logic/puc_regs.sv
// Protection unit control, region select, base and attribute registers with access verdict.
// Notes on behaviour
// [RULE_01] Control bit 0 enables protection.
// [RULE_02] Enabled, no background: unmatched access faults.
// [RULE_03] Background bit lets unmatched privileged accesses default.
// [RULE_04] Background bit ignored while unit disabled.
// [RULE_05] Handler bit clear: handlers bypass checking.
// [RULE_06] Handler bit set: handlers are checked too.
// [RULE_07] Software never sets handler bit while disabled.
// [RULE_08] No regions: only privileged execution allowed.
// [RULE_09] Unimplemented unit: control reads zero, ignores writes.
// [RULE_10] Region select holds region number, bits 7-0.
// [RULE_11] Software never selects an unimplemented region.
// [RULE_12] Software selects region before base or attributes.
// [RULE_13] Base write may name region and select it.
// [RULE_14] Base alignment is a fixed design parameter.
// [RULE_15] Software never names unimplemented region in base.
// [RULE_16] Word-only privileged access; otherwise hard fault.
// [RULE_17] Control register resets to zero.
// [RULE_18] Base write with bit 4 loads select low nibble.
// [RULE_19] Reserved bits read zero, writes ignored.
`timescale 1ns/1ns
module puc_regs #(
   parameter int NUM_REGIONS = puc_pkg::PUC_NUM_REGIONS,
   parameter int BASE_ALIGN_LSB = puc_pkg::PUC_BASE_ALIGN_LSB
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register access port
   input wire puc_pkg::puc_bus_req_t bus_req,
   output logic bus_resp_valid,
   output logic bus_hard_fault,
   output logic [31:0] bus_rdata,
   // Access path
   input wire puc_pkg::puc_access_t acc,
   output puc_pkg::puc_verdict_t verdict,
   // Settings seen by the access path
   output puc_pkg::puc_ctrl_t ctrl,
   output logic [puc_pkg::PUC_MAX_REGIONS-1:0][31:0] region_base,
   output logic [puc_pkg::PUC_MAX_REGIONS-1:0][31:0] region_attr,
   output logic any_region_enabled
);
   import puc_pkg::*;

   localparam logic IMPL = (NUM_REGIONS != 0);
   localparam logic [31:0] BASE_MASK = ~((32'h1 << BASE_ALIGN_LSB) - 32'h1) &
                                       ~((32'h1 << PUC_RBAR_LOW_W) - 32'h1); // RULE_14
   localparam logic [7:0] NUM_REGIONS_B = 8'(NUM_REGIONS);

   puc_ctrl_t ctrl_reg;
   logic [PUC_RNR_W-1:0] rnr_reg;
   logic [PUC_MAX_REGIONS-1:0][31:0] base_reg;
   logic [PUC_MAX_REGIONS-1:0][31:0] attr_reg;
   logic resp_valid_reg;
   logic fault_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_value;
   logic bus_ok;
   logic bus_bad;
   logic wr;
   logic rbar_named;
   logic [PUC_RBAR_REGION_W-1:0] named_idx;
   logic [PUC_RBAR_REGION_W-1:0] sel_idx;
   logic sel_ok;
   logic named_ok;

   // Word-sized privileged accesses only; anything else gets a hard fault.
   assign bus_ok = bus_req.valid && bus_req.priv && (bus_req.size == PUC_SIZE_WORD); // RULE_16
   assign bus_bad = bus_req.valid && !bus_ok; // RULE_16
   assign wr = bus_ok && bus_req.write;
   assign rbar_named = bus_req.wdata[PUC_RBAR_VALID_BIT];
   assign named_idx = bus_req.wdata[PUC_RBAR_REGION_W-1:0];
   assign sel_idx = rnr_reg[PUC_RBAR_REGION_W-1:0];
   // Out-of-range numbers are unpredictable; base and attribute writes through them are dropped and reads return zero.
   assign sel_ok = ({24'h0, rnr_reg} < 32'(NUM_REGIONS));
   assign named_ok = ({28'h0, named_idx} < 32'(NUM_REGIONS));

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= PUC_CTRL_RESET; // RULE_17
      end else if (wr && IMPL && bus_req.addr == PUC_ADDR_CTRL) begin
         ctrl_reg <= bus_req.wdata[PUC_CTRL_W-1:0]; // RULE_01 RULE_09 RULE_19
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rnr_reg <= PUC_RNR_RESET;
      end else if (wr && IMPL && bus_req.addr == PUC_ADDR_RNR) begin
         rnr_reg <= bus_req.wdata[PUC_RNR_W-1:0]; // RULE_10 RULE_19
      end else if (wr && IMPL && bus_req.addr == PUC_ADDR_RBAR && rbar_named) begin
         rnr_reg <= {{(PUC_RNR_W-PUC_RBAR_REGION_W){1'b0}}, named_idx}; // RULE_13 RULE_18
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         base_reg <= '0;
      end else if (wr && IMPL && bus_req.addr == PUC_ADDR_RBAR) begin
         if (rbar_named) begin
            if (named_ok) begin
               base_reg[named_idx] <= bus_req.wdata & BASE_MASK; // RULE_13
            end
         end else if (sel_ok) begin
            base_reg[sel_idx] <= bus_req.wdata & BASE_MASK; // RULE_13
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         attr_reg <= '0;
      end else if (wr && IMPL && sel_ok && bus_req.addr == PUC_ADDR_RASR) begin
         attr_reg[sel_idx] <= bus_req.wdata;
      end
   end

   always_comb begin
      rd_value = 32'h0;
      case (bus_req.addr)
         PUC_ADDR_TYPE: rd_value = {16'h0, NUM_REGIONS_B, 8'h0};
         PUC_ADDR_CTRL: rd_value = {29'h0, ctrl_reg}; // RULE_09 RULE_19
         PUC_ADDR_RNR: rd_value = {24'h0, rnr_reg}; // RULE_10 RULE_19
         PUC_ADDR_RBAR: rd_value = sel_ok ? (base_reg[sel_idx] | {28'h0, sel_idx}) : 32'h0;
         PUC_ADDR_RASR: rd_value = sel_ok ? attr_reg[sel_idx] : 32'h0;
         default: rd_value = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         resp_valid_reg <= 1'b0;
         fault_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         resp_valid_reg <= bus_req.valid;
         fault_reg <= bus_bad; // RULE_16
         rdata_reg <= (bus_ok && !bus_req.write) ? rd_value : 32'h0;
      end
   end

   always_comb begin
      any_region_enabled = 1'b0;
      for (int i = 0; i < PUC_MAX_REGIONS; i++) begin
         if (i < NUM_REGIONS && attr_reg[i][PUC_RASR_ENABLE_BIT]) begin
            any_region_enabled = 1'b1; // RULE_08
         end
      end
   end

   puc_decide u_decide (
      .ctrl(ctrl_reg),
      .acc(acc),
      .verdict(verdict)
   );

   assign bus_resp_valid = resp_valid_reg;
   assign bus_hard_fault = fault_reg;
   assign bus_rdata = rdata_reg;
   assign ctrl = ctrl_reg;
   assign region_base = base_reg;
   assign region_attr = attr_reg;

   // Checks on the verdict and on the register effects.
   sequence s_bypass;
      acc.in_handler && !ctrl_reg.handler_protection_enable;
   endsequence

   sequence s_named_base_write;
      wr && bus_req.addr == PUC_ADDR_RBAR && rbar_named;
   endsequence

   property p_disabled_default;
      @(posedge ref_clk) disable iff (!reset_n)
      acc.valid && !ctrl_reg.enable |-> verdict.use_default && !verdict.fault;
   endproperty
   a_disabled_default: assert property (p_disabled_default) else $error("disabled not default"); // RULE_01

   property p_no_background_fault;
      @(posedge ref_clk) disable iff (!reset_n)
      acc.valid && ctrl_reg.enable && !ctrl_reg.privileged_background_enable && !acc.region_hit &&
      !(acc.in_handler && !ctrl_reg.handler_protection_enable) |-> verdict.fault;
   endproperty
   a_no_background_fault: assert property (p_no_background_fault) else $error("miss no fault"); // RULE_02

   property p_priv_background;
      @(posedge ref_clk) disable iff (!reset_n)
      acc.valid && acc.priv && !acc.region_hit && ctrl_reg.enable &&
      ctrl_reg.privileged_background_enable |-> verdict.use_default && !verdict.fault;
   endproperty
   a_priv_background: assert property (p_priv_background) else $error("priv miss faulted"); // RULE_03

   property p_disabled_no_fault;
      @(posedge ref_clk) disable iff (!reset_n)
      !ctrl_reg.enable |-> !verdict.fault;
   endproperty
   a_disabled_no_fault: assert property (p_disabled_no_fault) else $error("fault when off"); // RULE_04

   property p_handler_bypass;
      @(posedge ref_clk) disable iff (!reset_n)
      acc.valid ##0 s_bypass |-> verdict.use_default && !verdict.fault;
   endproperty
   a_handler_bypass: assert property (p_handler_bypass) else $error("handler not bypassed"); // RULE_05

   property p_handler_checked;
      @(posedge ref_clk) disable iff (!reset_n)
      acc.valid && acc.in_handler && ctrl_reg.enable && ctrl_reg.handler_protection_enable &&
      !acc.region_hit && !(ctrl_reg.privileged_background_enable && acc.priv) |-> verdict.fault;
   endproperty
   a_handler_checked: assert property (p_handler_checked) else $error("handler unchecked"); // RULE_06

   property p_unpriv_exec_no_region;
      @(posedge ref_clk) disable iff (!reset_n)
      acc.valid && !acc.priv && !acc.region_hit && !any_region_enabled && ctrl_reg.enable &&
      !acc.in_handler |-> verdict.fault;
   endproperty
   a_unpriv_exec_no_region: assert property (p_unpriv_exec_no_region) else $error("unpriv ran"); // RULE_08

   property p_select_write;
      @(posedge ref_clk) disable iff (!reset_n)
      wr && IMPL && bus_req.addr == PUC_ADDR_RNR |=> rnr_reg == $past(bus_req.wdata[7:0]);
   endproperty
   a_select_write: assert property (p_select_write) else $error("select not stored"); // RULE_10

   property p_named_select;
      @(posedge ref_clk) disable iff (!reset_n)
      IMPL ##0 s_named_base_write |=>
      rnr_reg == {4'h0, $past(bus_req.wdata[3:0])} ##0 bus_resp_valid;
   endproperty
   a_named_select: assert property (p_named_select) else $error("named select wrong"); // RULE_18

   property p_unpriv_fault;
      @(posedge ref_clk) disable iff (!reset_n)
      bus_req.valid && !bus_req.priv |=> bus_resp_valid && bus_hard_fault && bus_rdata == 32'h0;
   endproperty
   a_unpriv_fault: assert property (p_unpriv_fault) else $error("unpriv access no fault"); // RULE_16

   property p_reset_ctrl;
      @(posedge ref_clk) $rose(reset_n) |-> ctrl_reg == PUC_CTRL_RESET;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not zero at reset"); // RULE_17

   property p_ctrl_reserved;
      @(posedge ref_clk) disable iff (!reset_n)
      bus_ok && !bus_req.write && bus_req.addr == PUC_ADDR_CTRL |=> bus_rdata[31:3] == 29'h0;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits set"); // RULE_19
endmodule : puc_regs

// >>> logic/puc_pkg.sv
// Package with the register map, field positions and carrier types of the protection controls.
package puc_pkg;
   // Word addresses of the protection registers.
   localparam logic [31:0] PUC_ADDR_TYPE = 32'he000ed90;
   localparam logic [31:0] PUC_ADDR_CTRL = 32'he000ed94;
   localparam logic [31:0] PUC_ADDR_RNR = 32'he000ed98;
   localparam logic [31:0] PUC_ADDR_RBAR = 32'he000ed9c;
   localparam logic [31:0] PUC_ADDR_RASR = 32'he000eda0;
   // Implementation choices.
   localparam int PUC_NUM_REGIONS = 8;
   localparam int PUC_MAX_REGIONS = 16;
   localparam int PUC_BASE_ALIGN_LSB = 8;
   // Field positions and widths.
   localparam int PUC_CTRL_W = 3;
   localparam int PUC_RNR_W = 8;
   localparam int PUC_RBAR_VALID_BIT = 4;
   localparam int PUC_RBAR_REGION_W = 4;
   localparam int PUC_RBAR_LOW_W = 5;
   localparam int PUC_RASR_ENABLE_BIT = 0;
   localparam logic [1:0] PUC_SIZE_WORD = 2'h2;
   localparam logic [PUC_CTRL_W-1:0] PUC_CTRL_RESET = 3'h0;
   localparam logic [PUC_RNR_W-1:0] PUC_RNR_RESET = 8'h00;

   typedef struct packed {
      logic privileged_background_enable;
      logic handler_protection_enable;
      logic enable;
   } puc_ctrl_t;

   typedef struct packed {
      logic valid;
      logic priv;
      logic in_handler;
      logic region_hit;
   } puc_access_t;

   typedef struct packed {
      logic use_default;
      logic fault;
   } puc_verdict_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic priv;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } puc_bus_req_t;
endpackage : puc_pkg

// >>> logic/puc_decide.sv
// Access verdict: default map, region permissions, or fault for one access.
`timescale 1ns/1ns
module puc_decide (
   // Settings and access
   input wire puc_pkg::puc_ctrl_t ctrl,
   input wire puc_pkg::puc_access_t acc,
   // Verdict
   output puc_pkg::puc_verdict_t verdict
);
   import puc_pkg::*;

   always_comb begin
      verdict = '0;
      if (acc.valid) begin
         if (!ctrl.enable) begin
            // Background bit and handler bit are both ignored here.
            verdict.use_default = 1'b1; // RULE_01 RULE_04
         end else if (acc.in_handler && !ctrl.handler_protection_enable) begin
            verdict.use_default = 1'b1; // RULE_05
         end else if (acc.region_hit) begin
            verdict.use_default = 1'b0; // RULE_06
         end else if (ctrl.privileged_background_enable && acc.priv) begin
            verdict.use_default = 1'b1; // RULE_03 RULE_08
         end else begin
            verdict.fault = 1'b1; // RULE_02 RULE_08
         end
      end
   end
endmodule : puc_decide

// >>> testbench/puc_core_model.sv
// Model of the core access path that presents one access per cycle to the protection unit.
`timescale 1ns/1ns
module puc_core_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Access wanted by the bench and access shown to the unit
   input wire puc_pkg::puc_access_t want,
   output puc_pkg::puc_access_t acc
);
   import puc_pkg::*;
   // An idle access shows inverted qualifiers so that no stale value can look meaningful.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc <= '0;
      end else if (want.valid) begin
         acc <= want;
      end else begin
         acc <= {1'b0, ~acc.priv, ~acc.in_handler, ~acc.region_hit};
      end
   end
endmodule : puc_core_model

// >>> testbench/protection_unit_control_regs_bench.sv
// Self-checking bench for the protection control and region select registers.
`timescale 1ns/1ns
module protection_unit_control_regs_bench;
   import puc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   puc_bus_req_t bus_req = '0;
   puc_access_t want = '0;
   puc_access_t acc;
   puc_verdict_t verdict;
   puc_ctrl_t ctrl;
   logic bus_resp_valid;
   logic bus_hard_fault;
   logic [31:0] bus_rdata;
   logic [PUC_MAX_REGIONS-1:0][31:0] region_base;
   logic [PUC_MAX_REGIONS-1:0][31:0] region_attr;
   logic any_region_enabled;
   puc_ctrl_t ctrl_none;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [31:0] seed = 32'h16;
   logic [2:0] cv_tab[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h3, 3'h7};
   int fails = 0;
   int n_tests = 0;

   always #4 ref_clk = ~ref_clk;

   puc_regs dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
      .bus_resp_valid(bus_resp_valid), .bus_hard_fault(bus_hard_fault), .bus_rdata(bus_rdata),
      .acc(acc), .verdict(verdict), .ctrl(ctrl), .region_base(region_base),
      .region_attr(region_attr), .any_region_enabled(any_region_enabled));
   puc_core_model core_u (.ref_clk(ref_clk), .reset_n(reset_n), .want(want), .acc(acc));
   // A copy built without regions sees the same traffic; its control must stay zero.
   puc_regs #(.NUM_REGIONS(0)) dut_none_u (.ref_clk(ref_clk), .reset_n(reset_n),
      .bus_req(bus_req), .bus_resp_valid(), .bus_hard_fault(), .bus_rdata(), .acc(acc),
      .verdict(), .ctrl(ctrl_none), .region_base(), .region_attr(), .any_region_enabled());

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   function automatic logic [1:0] exp_verdict(input logic [2:0] c, input logic [3:0] a);
      if (!a[3]) return 2'h0;
      if (!c[0]) return 2'h2;
      if (a[1] && !c[1]) return 2'h2;
      if (a[0]) return 2'h0;
      if (c[2] && a[2]) return 2'h2;
      return 2'h1;
   endfunction : exp_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      n_tests++;
      if (seen !== expd) begin
         fails++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask : check

   // Expected answers are queued at request time so back-to-back traffic stays in order.
   task automatic bus(input logic wr, input logic pv, input logic [1:0] sz,
      input logic [31:0] ad, input logic [31:0] wd, input logic [31:0] er, input logic ef);
      @(posedge ref_clk);
      bus_req <= '{valid: 1'b1, write: wr, priv: pv, size: sz, addr: ad, wdata: wd};
      exp_q.push_back({ef, er});
      @(posedge ref_clk);
      bus_req.valid <= 1'b0;
   endtask : bus

   task automatic wr(input logic [31:0] ad, input logic [31:0] wd);
      bus(1'b1, 1'b1, PUC_SIZE_WORD, ad, wd, 32'h0, 1'b0);
   endtask : wr

   task automatic rd(input logic [31:0] ad, input logic [31:0] er);
      bus(1'b0, 1'b1, PUC_SIZE_WORD, ad, 32'h0, er, 1'b0);
   endtask : rd

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   always @(posedge ref_clk) begin
      if (bus_resp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            e = exp_q.pop_front();
            check(bus_rdata, e[31:0]);
            check({31'h0, bus_hard_fault}, {31'h0, e[32]});
         end
      end
   end

   initial begin
      #200000;
      fails++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(PUC_ADDR_CTRL, 32'h0);
      check({29'h0, ctrl}, 32'h0);
      check({31'h0, any_region_enabled}, 32'h0);
      // Handler bit is only ever set together with enable, as software must.
      foreach (cv_tab[i]) begin
         seed = xs(seed);
         wr(PUC_ADDR_CTRL, {seed[31:3], cv_tab[i]});
         rd(PUC_ADDR_CTRL, {29'h0, cv_tab[i]});
         check({29'h0, ctrl}, {29'h0, cv_tab[i]});
         for (int a = 0; a < 16; a++) begin
            @(posedge ref_clk);
            want <= a[3:0];
            @(posedge ref_clk);
            #1;
            check({30'h0, verdict}, {30'h0, exp_verdict(cv_tab[i], a[3:0])});
         end
      end
      check({29'h0, ctrl_none}, 32'h0);
      bus(1'b1, 1'b0, PUC_SIZE_WORD, PUC_ADDR_CTRL, 32'h0, 32'h0, 1'b1);
      bus(1'b1, 1'b1, 2'h1, PUC_ADDR_CTRL, 32'h0, 32'h0, 1'b1);
      rd(PUC_ADDR_CTRL, 32'h7);
      seed = xs(seed);
      wr(PUC_ADDR_RNR, {seed[31:8], 8'h03});
      rd(PUC_ADDR_RNR, 32'h3);
      wr(PUC_ADDR_RASR, 32'h1);
      rd(PUC_ADDR_RASR, 32'h1);
      check({31'h0, any_region_enabled}, 32'h1);
      check(region_attr[3], 32'h1);
      wr(PUC_ADDR_RBAR, 32'h12345615);
      rd(PUC_ADDR_RNR, 32'h5);
      rd(PUC_ADDR_RBAR, 32'h12345605);
      check(region_base[5], 32'h12345600);
      check(region_base[3], 32'h0);
      rd(32'he000eda4, 32'h0);
      repeat (3) @(posedge ref_clk);
      check(exp_q.size(), 32'h0);
      complete_run();
   end
endmodule : protection_unit_control_regs_bench
